// File: hw/cs_consts.svh
// Constants of the control shadow monitor
`ifndef CS_CONSTS_SVH
`define CS_CONSTS_SVH
// ==========================================
// Function population
`define CS_FUNCS 10
`define CS_NUM_PF 4'h2
`define CS_VF_PER_PF 4'h4
`define CS_FIRST_FUNC 4'h0
`define CS_LAST_FUNC 4'h9
`define CS_FUNC_W 4
`define CS_PF_W 1
`define CS_VF_W 11
`define CS_CFG_W 7
// ==========================================
// Register port
`define CS_ADDR_W 8
`define CS_DATA_W 32
`define CS_SEL_LSB 2
`define CS_SEL_MSB 3
`define CS_FN_LSB 4
`define CS_FN_MSB 7
`define CS_REG_CMD 2'h0
`define CS_REG_MSIX 2'h1
`define CS_REG_TPH 2'h2
`define CS_REG_ATS 2'h3
`define CS_RD_IDLE 32'h0000_0000
// ==========================================
// Shadow positions and their source bits
`define CS_CFG_BME 0
`define CS_CFG_MSIX_MASK 1
`define CS_CFG_MSIX_EN 2
`define CS_CFG_TPH_LO 3
`define CS_CFG_TPH_HI 4
`define CS_CFG_TPH_EN 5
`define CS_CFG_ATS_EN 6
`define CS_SRC_BME 2
`define CS_SRC_MSIX_MASK 14
`define CS_SRC_MSIX_EN 15
`define CS_SRC_TPH_LO 0
`define CS_SRC_TPH_HI 1
`define CS_SRC_TPH_EN 8
`define CS_SRC_ATS_EN 15
// ==========================================
// Reset values
`define CS_CFG_RESET 7'h00
`define CS_VF_NONE 11'h000
`define CS_PF_NONE 1'h0
`endif

// File: hw/cs_pkg.sv
// Types of the control shadow monitor
`include "cs_consts.svh"
package cs_pkg;
	typedef logic [`CS_CFG_W-1:0] cs_cfg_t;
	typedef logic [`CS_FUNC_W-1:0] cs_func_t;
	typedef logic [`CS_DATA_W-1:0] cs_word_t;
	// Scan state, Gray along idle to scan
	typedef enum logic {
		CS_IDLE = 1'b0,
		CS_SCAN = 1'b1
	} cs_state_t;
endpackage

// File: hw/cs_shadow_if.sv
// Interface between the monitor core and its helpers
`timescale 1ns/1ps
`include "cs_consts.svh"
interface cs_shadow_if;
	logic [1:0] reg_sel;
	cs_pkg::cs_word_t wdata;
	cs_pkg::cs_cfg_t old_cfg;
	cs_pkg::cs_cfg_t new_cfg;
	cs_pkg::cs_word_t rd_data;
	cs_pkg::cs_func_t fn;
	logic [`CS_PF_W-1:0] pf_id;
	logic is_vf;
	logic [`CS_VF_W-1:0] vf_off;
	modport merge (input reg_sel, wdata, old_cfg, output new_cfg, rd_data);
	modport ident (input fn, output pf_id, is_vf, vf_off);
	modport core (output reg_sel, wdata, old_cfg, fn, input new_cfg, rd_data, pf_id, is_vf, vf_off);
endinterface

// File: hw/cs_field_merge.sv
// Maps control register words onto the shadow bits and back
`timescale 1ns/1ps
`include "cs_consts.svh"
module cs_field_merge (
	cs_shadow_if.merge m
);
	// ==========================================
	// Field merge and read-back
	always_comb begin
		m.new_cfg = m.old_cfg;
		m.rd_data = `CS_RD_IDLE;
		unique case (m.reg_sel)
			`CS_REG_CMD: begin
				m.new_cfg[`CS_CFG_BME] = m.wdata[`CS_SRC_BME];
				m.rd_data[`CS_SRC_BME] = m.old_cfg[`CS_CFG_BME];
			end
			`CS_REG_MSIX: begin
				m.new_cfg[`CS_CFG_MSIX_MASK] = m.wdata[`CS_SRC_MSIX_MASK];
				m.new_cfg[`CS_CFG_MSIX_EN] = m.wdata[`CS_SRC_MSIX_EN];
				m.rd_data[`CS_SRC_MSIX_MASK] = m.old_cfg[`CS_CFG_MSIX_MASK];
				m.rd_data[`CS_SRC_MSIX_EN] = m.old_cfg[`CS_CFG_MSIX_EN];
			end
			`CS_REG_TPH: begin
				m.new_cfg[`CS_CFG_TPH_HI:`CS_CFG_TPH_LO] = m.wdata[`CS_SRC_TPH_HI:`CS_SRC_TPH_LO];
				m.new_cfg[`CS_CFG_TPH_EN] = m.wdata[`CS_SRC_TPH_EN];
				m.rd_data[`CS_SRC_TPH_HI:`CS_SRC_TPH_LO] = m.old_cfg[`CS_CFG_TPH_HI:`CS_CFG_TPH_LO];
				m.rd_data[`CS_SRC_TPH_EN] = m.old_cfg[`CS_CFG_TPH_EN];
			end
			`CS_REG_ATS: begin
				m.new_cfg[`CS_CFG_ATS_EN] = m.wdata[`CS_SRC_ATS_EN];
				m.rd_data[`CS_SRC_ATS_EN] = m.old_cfg[`CS_CFG_ATS_EN];
			end
		endcase
	end
endmodule

// File: hw/cs_func_id.sv
// Turns a flat function index into owner PF and VF offset
`timescale 1ns/1ps
`include "cs_consts.svh"
module cs_func_id (
	cs_shadow_if.ident m
);
	logic [`CS_FUNC_W-1:0] vidx;
	logic [`CS_FUNC_W-1:0] vpf;
	logic [`CS_FUNC_W-1:0] voff;

	// ==========================================
	// VF position within the flat index
	assign vidx = m.fn - `CS_NUM_PF;
	assign vpf = vidx / `CS_VF_PER_PF;
	assign voff = vidx % `CS_VF_PER_PF;

	// PFs come first, then each PF's VFs in turn
	always_comb begin
		if (m.fn < `CS_NUM_PF) begin
			m.pf_id = m.fn[`CS_PF_W-1:0];
			m.is_vf = 1'b0;
			m.vf_off = `CS_VF_NONE;
		end else begin
			m.pf_id = vpf[`CS_PF_W-1:0];
			m.is_vf = 1'b1;
			m.vf_off = {{(`CS_VF_W-`CS_FUNC_W){1'b0}}, voff};
		end
	end
endmodule

// File: hw/cs_shadow_monitor.sv
// Control shadow monitor: reports function control fields to user logic
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "cs_consts.svh"

module cs_shadow_monitor (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Configuration register port
	input wire logic [`CS_ADDR_W-1:0] addr_in,
	input wire logic [`CS_DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [`CS_DATA_W-1:0] rdata_out,
	// Scan request
	input wire logic scan_req_all_in,
	// Shadow report
	output logic shadow_update_out,
	output logic [`CS_CFG_W-1:0] shadow_cfg_out,
	output logic [`CS_PF_W-1:0] shadow_phys_func_id_out,
	output logic shadow_is_virtual_func_out,
	output logic [`CS_VF_W-1:0] shadow_virt_func_offset_out
);
	// ==========================================
	// Declarations
	cs_shadow_if sh ();
	cs_pkg::cs_cfg_t mem [`CS_FUNCS];
	cs_pkg::cs_cfg_t next_mem [`CS_FUNCS];
	cs_pkg::cs_state_t state;
	cs_pkg::cs_state_t next_state;
	cs_pkg::cs_func_t ptr;
	cs_pkg::cs_func_t next_ptr;
	cs_pkg::cs_func_t acc_fn;
	cs_pkg::cs_func_t show_fn;
	cs_pkg::cs_cfg_t show_cfg;
	logic show;
	logic scan_end;
	logic acc_hit;
	logic changed;
	logic next_update;
	cs_pkg::cs_cfg_t next_cfg;
	logic [`CS_PF_W-1:0] next_pf;
	logic next_is_vf;
	logic [`CS_VF_W-1:0] next_vf_off;
	cs_pkg::cs_word_t next_rdata;

	// ==========================================
	// Helpers
	cs_field_merge u_merge (
		.m(sh.merge)
	);

	cs_func_id u_ident (
		.m(sh.ident)
	);

	// Address decode shared by read and write
	assign acc_fn = addr_in[`CS_FN_MSB:`CS_FN_LSB];
	assign acc_hit = acc_fn < `CS_NUM_PF + `CS_VF_PER_PF * `CS_NUM_PF;
	assign sh.reg_sel = addr_in[`CS_SEL_MSB:`CS_SEL_LSB];
	assign sh.wdata = wdata_in;
	assign sh.old_cfg = acc_hit ? mem[acc_fn] : `CS_CFG_RESET;
	assign sh.fn = show_fn;

	// A write counts only when it really alters a field
	assign changed = wr_in && acc_hit && (sh.new_cfg != sh.old_cfg);

	// ==========================================
	// Next state of store, scan and report
	always_comb begin
		next_mem = mem;
		next_state = state;
		next_ptr = ptr;
		show = 1'b0;
		scan_end = 1'b0;
		show_fn = ptr;
		show_cfg = mem[ptr];
		// Store every accepted write
		if (wr_in && acc_hit) begin
			next_mem[acc_fn] = sh.new_cfg;
		end
		if (changed) begin
			// Written function goes out ahead of the scan
			show = 1'b1;
			show_fn = acc_fn;
			show_cfg = sh.new_cfg;
			if (state == cs_pkg::CS_SCAN) begin
				// Writing the last function also closes the scan
				if (acc_fn == `CS_LAST_FUNC) begin
					scan_end = 1'b1;
				end else begin
					// Resume after the written one, even behind the pointer
					next_ptr = acc_fn + 4'h1;
				end
			end
		end else if (state == cs_pkg::CS_SCAN) begin
			// One function per cycle, each with its own strobe
			show = 1'b1;
			if (ptr == `CS_LAST_FUNC) begin
				scan_end = 1'b1;
			end else begin
				next_ptr = ptr + 4'h1;
			end
		end else if (scan_req_all_in) begin
			next_state = cs_pkg::CS_SCAN;
			next_ptr = `CS_FIRST_FUNC;
		end
		// During a scan the request is looked at only when the scan finishes
		if (scan_end) begin
			next_ptr = `CS_FIRST_FUNC;
			next_state = scan_req_all_in ? cs_pkg::CS_SCAN : cs_pkg::CS_IDLE;
		end
	end

	// Report outputs, zero outside strobe cycles
	always_comb begin
		next_update = show;
		next_cfg = show ? show_cfg : `CS_CFG_RESET;
		next_pf = show ? sh.pf_id : `CS_PF_NONE;
		next_is_vf = show & sh.is_vf;
		next_vf_off = show ? sh.vf_off : `CS_VF_NONE;
	end

	// Read data one cycle after the strobe; refused functions read zero
	always_comb begin
		next_rdata = (rd_in && acc_hit) ? sh.rd_data : `CS_RD_IDLE;
	end

	// ==========================================
	// Registers
	// Store and scan state
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mem <= '{default: `CS_CFG_RESET};
			state <= cs_pkg::CS_IDLE;
			ptr <= `CS_FIRST_FUNC;
		end else begin
			mem <= next_mem;
			state <= next_state;
			ptr <= next_ptr;
		end
	end

	// Report outputs, each straight from its flop
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			shadow_update_out <= 1'b0;
			shadow_cfg_out <= `CS_CFG_RESET;
			shadow_phys_func_id_out <= `CS_PF_NONE;
			shadow_is_virtual_func_out <= 1'b0;
			shadow_virt_func_offset_out <= `CS_VF_NONE;
		end else begin
			shadow_update_out <= next_update;
			shadow_cfg_out <= next_cfg;
			shadow_phys_func_id_out <= next_pf;
			shadow_is_virtual_func_out <= next_is_vf;
			shadow_virt_func_offset_out <= next_vf_off;
		end
	end

	// Read data register
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rdata_out <= `CS_RD_IDLE;
		end else begin
			rdata_out <= next_rdata;
		end
	end

	// ==========================================
	// Assertions
	write_report_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		changed |=> shadow_update_out && shadow_cfg_out == $past(sh.new_cfg))
		else $error("changed write not reported next cycle");

	vf_ident_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		changed && acc_fn >= `CS_NUM_PF |=> shadow_is_virtual_func_out &&
			shadow_virt_func_offset_out == {7'h00, $past((acc_fn - `CS_NUM_PF) % `CS_VF_PER_PF)})
		else $error("virtual function identity wrong on update");

	bme_map_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		changed && sh.reg_sel == `CS_REG_CMD |=>
			shadow_cfg_out[`CS_CFG_BME] == $past(wdata_in[`CS_SRC_BME]))
		else $error("bus master enable not on shadow bit 0");

	msix_map_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		changed && sh.reg_sel == `CS_REG_MSIX |=>
			shadow_cfg_out[`CS_CFG_MSIX_EN:`CS_CFG_MSIX_MASK] ==
			$past(wdata_in[`CS_SRC_MSIX_EN:`CS_SRC_MSIX_MASK]))
		else $error("MSI-X bits misplaced");

	tph_map_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		changed && sh.reg_sel == `CS_REG_TPH |=>
			shadow_cfg_out[`CS_CFG_TPH_HI:`CS_CFG_TPH_LO] == $past(wdata_in[`CS_SRC_TPH_HI:`CS_SRC_TPH_LO]) &&
			shadow_cfg_out[`CS_CFG_TPH_EN] == $past(wdata_in[`CS_SRC_TPH_EN]))
		else $error("TPH bits misplaced");

	ats_map_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		changed && sh.reg_sel == `CS_REG_ATS |=>
			shadow_cfg_out[`CS_CFG_ATS_EN] == $past(wdata_in[`CS_SRC_ATS_EN]))
		else $error("ATS enable misplaced");

	pf_ident_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		changed && acc_fn < `CS_NUM_PF |=> !shadow_is_virtual_func_out &&
			shadow_phys_func_id_out == $past(acc_fn[`CS_PF_W-1:0]))
		else $error("physical function identity wrong");

	vf_range_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		shadow_is_virtual_func_out |-> shadow_update_out &&
			shadow_virt_func_offset_out < {7'h00, `CS_VF_PER_PF})
		else $error("VF offset out of range or flag without strobe");

	quiet_cfg_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		!shadow_update_out |-> shadow_cfg_out == `CS_CFG_RESET)
		else $error("shadow values driven outside strobe");

	scan_walk_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		state == cs_pkg::CS_SCAN && !changed && ptr != `CS_LAST_FUNC |=>
			shadow_update_out ##0 ptr == $past(ptr) + 4'h1)
		else $error("scan did not present and advance");

	scan_resume_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		state == cs_pkg::CS_SCAN && changed && acc_fn != `CS_LAST_FUNC |=>
			state == cs_pkg::CS_SCAN && ptr == $past(acc_fn) + 4'h1)
		else $error("scan did not resume after written function");

	scan_restart_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		scan_end |=> state == (($past(scan_req_all_in)) ? cs_pkg::CS_SCAN : cs_pkg::CS_IDLE) &&
			ptr == `CS_FIRST_FUNC)
		else $error("scan end did not follow the request");

	// Identities, store, quiet periods and scan
	vf_owner_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		changed && acc_fn >= `CS_NUM_PF |=>
			{3'h0, shadow_phys_func_id_out} == $past((acc_fn - `CS_NUM_PF) / `CS_VF_PER_PF))
		else $error("owning physical function wrong on update");

	pf_offset_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		changed && acc_fn < `CS_NUM_PF |=> shadow_virt_func_offset_out == `CS_VF_NONE)
		else $error("VF offset driven for a physical function");

	write_store_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		wr_in && acc_hit |=> mem[$past(acc_fn)] == $past(sh.new_cfg))
		else $error("accepted write not stored");

	idle_quiet_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		state == cs_pkg::CS_IDLE && !changed |=> !shadow_update_out)
		else $error("strobe without change or scan");

	quiet_ids_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		!shadow_update_out |-> !shadow_is_virtual_func_out &&
			shadow_phys_func_id_out == `CS_PF_NONE && shadow_virt_func_offset_out == `CS_VF_NONE)
		else $error("identities driven outside strobe");

	scan_start_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		state == cs_pkg::CS_IDLE && !changed && scan_req_all_in |=>
			state == cs_pkg::CS_SCAN && ptr == `CS_FIRST_FUNC)
		else $error("scan request did not start a scan");

	scan_cfg_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		state == cs_pkg::CS_SCAN && !changed |=> shadow_update_out && shadow_cfg_out == $past(mem[ptr]))
		else $error("scanned settings wrong");

	scan_pf_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		state == cs_pkg::CS_SCAN && !changed && ptr < `CS_NUM_PF |=>
			!shadow_is_virtual_func_out && {3'h0, shadow_phys_func_id_out} == $past(ptr))
		else $error("scanned physical function identity wrong");

	scan_vf_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		state == cs_pkg::CS_SCAN && !changed && ptr >= `CS_NUM_PF |=> shadow_is_virtual_func_out &&
			shadow_virt_func_offset_out == {7'h00, $past((ptr - `CS_NUM_PF) % `CS_VF_PER_PF)})
		else $error("scanned virtual function identity wrong");

	scan_hold_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		state == cs_pkg::CS_SCAN && !scan_end |=> state == cs_pkg::CS_SCAN)
		else $error("scan left before its end");

	scan_last_a: assert property (
		@(posedge clk_in) disable iff (reset_in)
		state == cs_pkg::CS_SCAN && !changed && ptr == `CS_LAST_FUNC |=>
			shadow_update_out && ptr == `CS_FIRST_FUNC)
		else $error("last function not shown or pointer not rewound");
endmodule

// File: tb/cs_user_model.sv
// User-side model that keeps every strobed shadow report
`timescale 1ns/1ps
`include "cs_consts.svh"
module cs_user_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Shadow report
	input wire logic update_in,
	input wire logic [`CS_CFG_W-1:0] cfg_in,
	input wire logic [`CS_PF_W-1:0] pf_in,
	input wire logic is_vf_in,
	input wire logic [`CS_VF_W-1:0] vf_off_in
);
	int cycle = 0;
	int log_fn[$];
	int log_t[$];
	logic [`CS_CFG_W-1:0] log_cfg[$];
	// Copy values only in the strobe cycle; the device keeps nothing
	always @(posedge clk_in) begin
		cycle <= cycle + 1;
		if (!reset_in && update_in === 1'b1) begin
			log_fn.push_back(is_vf_in ? 2 + 4 * pf_in + vf_off_in : pf_in);
			log_cfg.push_back(cfg_in);
			log_t.push_back(cycle);
		end
	end
endmodule

// File: tb/cs_shadow_monitor_tb.sv
// Self-checking testbench of the control shadow monitor
`timescale 1ns/1ps
`include "cs_consts.svh"
module cs_shadow_monitor_tb;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [`CS_ADDR_W-1:0] addr_in = 8'h00;
	logic [`CS_DATA_W-1:0] wdata_in = 32'h0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic scan_req_all_in = 1'b0;
	logic [`CS_DATA_W-1:0] rdata_out;
	logic upd;
	logic [`CS_CFG_W-1:0] cfg;
	logic [`CS_PF_W-1:0] pf;
	logic is_vf;
	logic [`CS_VF_W-1:0] vf_off;
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;
	int base;
	int p;
	logic [6:0] exp_cfg [10] = '{default: 7'h00};
	logic [1:0] sel_tab [7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3};
	int src_tab [7] = '{2, 14, 15, 0, 1, 8, 15};

	// ==========
	// Design and user-side model
	cs_shadow_monitor u_cs_shadow_monitor (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.scan_req_all_in(scan_req_all_in), .shadow_update_out(upd), .shadow_cfg_out(cfg),
		.shadow_phys_func_id_out(pf), .shadow_is_virtual_func_out(is_vf),
		.shadow_virt_func_offset_out(vf_off));
	cs_user_model u_cs_user_model (.clk_in(clk_in), .reset_in(reset_in), .update_in(upd),
		.cfg_in(cfg), .pf_in(pf), .is_vf_in(is_vf), .vf_off_in(vf_off));

	// Clock and hang guard
	always #2 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			error_cnt++;
			print_verdict();
		end
	end

	// ==========
	// Tasks
	task automatic print_verdict();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One-cycle write; returns just after the edge that takes it
	task automatic wr(input int fn, input logic [1:0] sel, input logic [31:0] d);
		@(posedge clk_in);
		addr_in <= {fn[3:0], sel, 2'h0};
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		#1;
	endtask

	// One-cycle read; data only in the next cycle
	task automatic rd(input int fn, input logic [1:0] sel, input logic [31:0] exp);
		@(posedge clk_in);
		addr_in <= {fn[3:0], sel, 2'h0};
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		chk("rdata", exp, rdata_out);
		@(posedge clk_in);
		#1;
		chk("rdata_idle", 0, rdata_out);
	endtask

	// Report of one function, then quiet outputs
	task automatic chk_report(input int fn, input logic [6:0] c);
		chk("update", 1, upd);
		chk("cfg", c, cfg);
		chk("pf", fn < 2 ? fn : (fn - 2) / 4, pf);
		chk("is_vf", fn >= 2, is_vf);
		chk("vf_off", fn < 2 ? 0 : (fn - 2) % 4, vf_off);
		@(posedge clk_in);
		#1;
		chk("update_drop", 0, upd);
		chk("cfg_idle", 0, cfg);
	endtask

	task automatic wait_log(input int target);
		for (int n = 0; n < 100 && u_cs_user_model.log_fn.size() < target; n++) begin
			@(posedge clk_in);
			#1;
		end
	endtask

	// ==========
	// Main sequence
	initial begin
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		#1;
		chk("reset_update", 0, upd);
		// One field per function across all four registers
		for (int i = 0; i < 7; i++) begin
			wr(i + 2, sel_tab[i], 32'h1 << src_tab[i]);
			chk_report(i + 2, 7'h01 << i);
			rd(i + 2, sel_tab[i], 32'h1 << src_tab[i]);
			exp_cfg[i + 2] = 7'h01 << i;
		end
		// Unchanged value gives no report
		wr(2, 2'h0, 32'h4);
		chk("unchanged", 0, upd);
		// Physical functions; unmapped bits dropped
		wr(1, 2'h0, 32'h4);
		chk_report(1, 7'h01);
		wr(0, 2'h2, 32'hFFFF_FFFF);
		chk_report(0, 7'h38);
		rd(0, 2'h2, 32'h0000_0103);
		exp_cfg[0] = 7'h38;
		exp_cfg[1] = 7'h01;
		// Index past the population is refused
		wr(12, 2'h0, 32'h4);
		chk("refused", 0, upd);
		rd(12, 2'h0, 32'h0);
		// Scan broken by a write, then a second scan back to back
		base = u_cs_user_model.log_fn.size();
		@(posedge clk_in);
		scan_req_all_in <= 1'b1;
		wait_log(base + 3);
		wr(7, 2'h3, 32'h0000_8000);
		exp_cfg[7] = 7'h60;
		wait_log(base + 12);
		@(posedge clk_in);
		scan_req_all_in <= 1'b0;
		repeat (30) @(posedge clk_in);
		#1;
		p = 0;
		while (p < 10 && u_cs_user_model.log_fn[base + p] == p) p++;
		for (int q = 0; q < p + 13; q++) begin
			int f;
			f = q < p ? q : (q < p + 3 ? q - p + 7 : q - p - 3);
			chk("scan_fn", f, u_cs_user_model.log_fn[base + q]);
			chk("scan_cfg", exp_cfg[f], u_cs_user_model.log_cfg[base + q]);
		end
		chk("scan_len", base + p + 13, u_cs_user_model.log_fn.size());
		chk("no_gap", u_cs_user_model.log_t[base + p + 2] + 1, u_cs_user_model.log_t[base + p + 3]);
		// Reset in mid-run clears the store
		@(posedge clk_in);
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		#1;
		chk("reset_update", 0, upd);
		rd(0, 2'h2, 32'h0);
		print_verdict();
	end
endmodule
